// *** hw/bmcfg_err_gate.sv ***
// Per-initiator gate that turns unmapped accesses into bus error answers.
`timescale 1ns/1ns
module bmcfg_err_gate #(
  parameter int N = 5
) (
  // Clock and reset.
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  // Enables and debug exemption.
  input  wire logic [N-1:0] enable_i,
  input  wire logic [N-1:0] exempt_i,
  // Unmapped access strobes and error answers.
  input  wire logic [N-1:0] unmapped_i,
  output logic      [N-1:0] bus_error_o
);

  logic [N-1:0] next_bus_error;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_gate
      // An exempt initiator never sees the error, whatever its enable says.
      assign next_bus_error[g] = unmapped_i[g] & enable_i[g] & ~exempt_i[g];
    end
  endgenerate

  // One register for all initiators, so the output has a single driving process.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_error_o <= {N{1'b0}};
    end else begin
      bus_error_o <= next_bus_error;
    end
  end

endmodule // bmcfg_err_gate

// *** hw/bmcfg_pkg.sv ***
// Package with the register map, field layout and reset values of the bus matrix config bank.
package bmcfg_pkg;

  // Register byte offsets within the bank.
  localparam logic [7:0] BMCFG_CONFIG_OFS      = 8'h00;
  localparam logic [7:0] BMCFG_KERN_PROG_OFS   = 8'h10;
  localparam logic [7:0] BMCFG_USER_DATA_OFS   = 8'h20;
  localparam logic [7:0] BMCFG_RAM_SIZE_OFS    = 8'h40;

  // Alias offsets added to a register's own offset.
  localparam logic [3:0] BMCFG_ALIAS_WRITE     = 4'h0;
  localparam logic [3:0] BMCFG_ALIAS_CLEAR     = 4'h4;
  localparam logic [3:0] BMCFG_ALIAS_SET       = 4'h8;
  localparam logic [3:0] BMCFG_ALIAS_INVERT    = 4'hc;

  // Configuration register field positions.
  localparam int         BMCFG_ERR_LSB         = 16;
  localparam int         BMCFG_ERR_CPU_INSTR   = 0;
  localparam int         BMCFG_ERR_CPU_DATA    = 1;
  localparam int         BMCFG_ERR_DMA         = 2;
  localparam int         BMCFG_ERR_DEBUG       = 3;
  localparam int         BMCFG_ERR_SHARED_BUS  = 4;
  localparam int         BMCFG_INITIATORS      = 5;
  localparam int         BMCFG_WAIT_STATE_BIT  = 6;
  localparam int         BMCFG_ARB_LSB         = 0;

  // Writable masks and reset values.
  localparam logic [31:0] BMCFG_CONFIG_MASK    = 32'h001f_0047;
  localparam logic [31:0] BMCFG_CONFIG_RESET   = 32'h001f_0041;
  localparam logic [31:0] BMCFG_BASE_MASK      = 32'h0000_fc00;
  localparam logic [31:0] BMCFG_BASE_RESET     = 32'h0000_0000;

  // Default data RAM size in bytes.
  localparam logic [31:0] BMCFG_RAM_SIZE_DEF   = 32'h0001_0000;

  // Arbitration mode encodings.
  localparam logic [2:0]  BMCFG_ARB_MODE0      = 3'h0;
  localparam logic [2:0]  BMCFG_ARB_MODE1      = 3'h1;
  localparam logic [2:0]  BMCFG_ARB_MODE2      = 3'h2;

  // Data RAM partition a CPU access falls into.
  typedef enum logic [1:0] {
    BMCFG_PART_KERNEL_DATA,
    BMCFG_PART_KERNEL_PROG,
    BMCFG_PART_USER_DATA
  } bmcfg_part_type;

endpackage

// *** hw/bmcfg_top.sv ***
// Bus matrix configuration bank with its Avalon-MM slave, error gating and data RAM wait state.
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
module bmcfg_top
  import bmcfg_pkg::*;
#(
  parameter logic [31:0] RAM_SIZE = BMCFG_RAM_SIZE_DEF
) (
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // Avalon-MM slave.
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Unmapped access strobes per initiator, with debug mode state.
  input  wire logic [4:0]  unmapped_access_i,
  input  wire logic        debug_mode_i,
  output logic      [4:0]  bus_error_o,
  // CPU data RAM access.
  input  wire logic        cpu_ram_req_i,
  input  wire logic [15:0] cpu_ram_addr_i,
  output logic             cpu_ram_ready_o,
  output bmcfg_part_type   cpu_ram_part_o,
  // Configuration seen by the bus matrix.
  output logic [2:0]       arbitration_mode_select_o,
  output logic             ram_wait_state_select_o,
  output logic [15:0]      ram_kernel_program_base_o,
  output logic [15:0]      ram_user_data_base_o
);

  // Stored registers; only their writable bits ever change.
  logic [31:0] bus_matrix_config;
  logic [31:0] ram_kernel_program_base;
  logic [31:0] ram_user_data_base;

  // Bus handshake state.
  logic        ack;
  logic        access;
  logic [7:0]  reg_base;
  logic [3:0]  alias_sel;
  logic [31:0] be_mask;
  logic [31:0] next_read;

  // The slave answers one cycle after a request arrives; the ack flop keeps a
  // held request from being taken twice.
  assign access    = (avs_read_i | avs_write_i) & ~ack;
  assign reg_base  = {avs_address_i[7:4], 4'h0};
  assign alias_sel = avs_address_i[3:0];

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      be_mask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
    end
  end

  // Computes the new register value for a write through any alias.
  function automatic logic [31:0] apply_write(
    input logic [31:0] old_val,
    input logic [31:0] wdata,
    input logic [31:0] lanes,
    input logic [31:0] wmask,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    logic [31:0] m;
    res = old_val;
    m   = lanes & wmask;
    case (sel)
      BMCFG_ALIAS_WRITE:  res = (old_val & ~m) | (wdata & m);
      BMCFG_ALIAS_CLEAR:  res = old_val & ~(wdata & m);
      BMCFG_ALIAS_SET:    res = old_val | (wdata & m);
      BMCFG_ALIAS_INVERT: res = old_val ^ (wdata & m);
      default:            res = old_val;
    endcase
    return res;
  endfunction

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= access;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~access;
    end
  end

  // Read mux; unimplemented bits are masked to zero, and alias addresses read as zero.
  always_comb begin
    next_read = 32'h0000_0000;
    if (alias_sel == BMCFG_ALIAS_WRITE) begin
      case (reg_base)
        BMCFG_CONFIG_OFS:    next_read = bus_matrix_config & BMCFG_CONFIG_MASK;
        BMCFG_KERN_PROG_OFS: next_read = ram_kernel_program_base & BMCFG_BASE_MASK;
        BMCFG_USER_DATA_OFS: next_read = ram_user_data_base & BMCFG_BASE_MASK;
        BMCFG_RAM_SIZE_OFS:  next_read = RAM_SIZE;
        default:             next_read = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (access && avs_read_i) begin
      avs_readdata_o <= next_read;
    end
  end

  // Writes land at the edge where waitrequest is low, using the held request.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_matrix_config <= BMCFG_CONFIG_RESET;
    end else if (ack && avs_write_i && reg_base == BMCFG_CONFIG_OFS) begin
      bus_matrix_config <= apply_write(bus_matrix_config, avs_writedata_i, be_mask,
                                       BMCFG_CONFIG_MASK, alias_sel);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ram_kernel_program_base <= BMCFG_BASE_RESET;
    end else if (ack && avs_write_i && reg_base == BMCFG_KERN_PROG_OFS) begin
      ram_kernel_program_base <= apply_write(ram_kernel_program_base, avs_writedata_i,
                                             be_mask, BMCFG_BASE_MASK, alias_sel);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ram_user_data_base <= BMCFG_BASE_RESET;
    end else if (ack && avs_write_i && reg_base == BMCFG_USER_DATA_OFS) begin
      ram_user_data_base <= apply_write(ram_user_data_base, avs_writedata_i,
                                        be_mask, BMCFG_BASE_MASK, alias_sel);
    end
  end

  // Configuration outputs, one flop stage behind the registers.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      arbitration_mode_select_o <= BMCFG_ARB_MODE1;
      ram_wait_state_select_o   <= BMCFG_CONFIG_RESET[BMCFG_WAIT_STATE_BIT];
      ram_kernel_program_base_o <= BMCFG_BASE_RESET[15:0];
      ram_user_data_base_o      <= BMCFG_BASE_RESET[15:0];
    end else begin
      // Reserved encodings are passed on unchanged; software must not use them.
      arbitration_mode_select_o <= bus_matrix_config[BMCFG_ARB_LSB +: 3];
      ram_wait_state_select_o   <= bus_matrix_config[BMCFG_WAIT_STATE_BIT];
      ram_kernel_program_base_o <= ram_kernel_program_base[15:0];
      ram_user_data_base_o      <= ram_user_data_base[15:0];
    end
  end

  // Error gating; the CPU initiators are exempt while the core is in debug mode.
  logic [4:0] err_enable;
  logic [4:0] err_exempt;

  assign err_enable = bus_matrix_config[BMCFG_ERR_LSB +: BMCFG_INITIATORS];
  always_comb begin
    err_exempt                      = 5'h00;
    err_exempt[BMCFG_ERR_CPU_INSTR] = debug_mode_i;
    err_exempt[BMCFG_ERR_CPU_DATA]  = debug_mode_i;
  end

  bmcfg_err_gate #(
    .N (BMCFG_INITIATORS)
  ) u_err_gate (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .enable_i    (err_enable),
    .exempt_i    (err_exempt),
    .unmapped_i  (unmapped_access_i),
    .bus_error_o (bus_error_o)
  );

  // Data RAM access sequencing; the setup state is the optional wait state.
  typedef enum logic [1:0] {
    BMCFG_RAM_IDLE,
    BMCFG_RAM_SETUP,
    BMCFG_RAM_DONE
  } bmcfg_ram_state_type;

  bmcfg_ram_state_type ram_state;
  bmcfg_ram_state_type next_ram_state;

  always_comb begin
    next_ram_state = ram_state;
    case (ram_state)
      BMCFG_RAM_IDLE: begin
        if (cpu_ram_req_i) begin
          next_ram_state = bus_matrix_config[BMCFG_WAIT_STATE_BIT] ?
                           BMCFG_RAM_SETUP : BMCFG_RAM_DONE;
        end
      end
      BMCFG_RAM_SETUP: next_ram_state = BMCFG_RAM_DONE;
      BMCFG_RAM_DONE:  next_ram_state = BMCFG_RAM_IDLE;
      default:         next_ram_state = BMCFG_RAM_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ram_state <= BMCFG_RAM_IDLE;
    end else begin
      ram_state <= next_ram_state;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_ram_ready_o <= 1'b0;
    end else begin
      cpu_ram_ready_o <= (next_ram_state == BMCFG_RAM_DONE);
    end
  end

  // Partition lookup; a zero base means that partition is absent, so an
  // untouched bank maps all of data RAM to kernel data.
  logic [15:0]    kp_base;
  logic [15:0]    ud_base;
  bmcfg_part_type next_part;

  assign kp_base = ram_kernel_program_base[15:0] & BMCFG_BASE_MASK[15:0];
  assign ud_base = ram_user_data_base[15:0] & BMCFG_BASE_MASK[15:0];

  always_comb begin
    next_part = BMCFG_PART_KERNEL_DATA;
    if (ud_base != 16'h0000 && cpu_ram_addr_i >= ud_base) begin
      next_part = BMCFG_PART_USER_DATA;
    end else if (kp_base != 16'h0000 && cpu_ram_addr_i >= kp_base) begin
      next_part = BMCFG_PART_KERNEL_PROG;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_ram_part_o <= BMCFG_PART_KERNEL_DATA;
    end else if (cpu_ram_req_i && ram_state == BMCFG_RAM_IDLE) begin
      cpu_ram_part_o <= next_part;
    end
  end

endmodule // bmcfg_top

// *** testbench/bmcfg_initiators.sv ***
// Model of the bus initiators that face the configuration bank.
`timescale 1ns/1ns
module bmcfg_initiators (
  // Clock, reset and bench commands.
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  err_go_i,
  input  wire logic        ram_go_i,
  input  wire logic [15:0] ram_addr_i,
  // Initiator side of the bank.
  output logic      [4:0]  unmapped_access_o,
  output logic             cpu_ram_req_o,
  output logic      [15:0] cpu_ram_addr_o
);
  // The address means nothing between requests, so it inverts itself every cycle there.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      unmapped_access_o <= 5'h00;
      cpu_ram_req_o     <= 1'b0;
      cpu_ram_addr_o    <= 16'h0000;
    end else begin
      unmapped_access_o <= err_go_i;
      cpu_ram_req_o     <= ram_go_i;
      cpu_ram_addr_o    <= ram_go_i ? ram_addr_i : ~cpu_ram_addr_o;
    end
  end
endmodule // bmcfg_initiators

// *** testbench/bmcfg_monitor.sv ***
// Checker of the configuration bank port behaviour.
`timescale 1ns/1ns
module bmcfg_monitor import bmcfg_pkg::*; #(
  parameter logic [31:0] RAM_SIZE = BMCFG_RAM_SIZE_DEF
) (
  // Watched ports.
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [4:0]  unmapped_access_i,
  input wire logic        debug_mode_i,
  input wire logic [4:0]  bus_error_o,
  input wire logic        cpu_ram_req_i,
  input wire logic        cpu_ram_ready_o,
  input wire logic        ram_wait_state_select_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic busy;
  logic ack;
  assign ack = avs_read_i && !avs_waitrequest_o;
  // A RAM request is only taken while idle, so the open access is tracked.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) busy <= 1'b0;
    else if (cpu_ram_req_i && !busy) busy <= 1'b1;
    else if (cpu_ram_ready_o) busy <= 1'b0;
  end
  sequence s_take(logic w);
    cpu_ram_req_i && !busy && ram_wait_state_select_o == w;
  endsequence
  sequence s_late;
    !cpu_ram_ready_o ##1 cpu_ram_ready_o;
  endsequence
  chk_ram_nowait: assert property (s_take(1'b0) |=> cpu_ram_ready_o)
    else $error("ready missing without wait state");
  chk_ram_onewait: assert property (s_take(1'b1) |=> s_late)
    else $error("ready timing wrong with wait state");
  chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus answer late");
  chk_ack_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("acknowledge longer than one cycle");
  chk_cfg_unused: assert property (ack && avs_address_i == 8'h00
    |-> (avs_readdata_o & ~32'h001f_0047) == 32'h0) else $error("config unused bits set");
  chk_base_fixed: assert property (ack && avs_address_i inside {8'h10, 8'h20}
    |-> avs_readdata_o[31:16] == 16'h0 && avs_readdata_o[9:0] == 10'h0)
    else $error("base fixed bits set");
  chk_size_value: assert property (ack && avs_address_i == 8'h40
    |-> avs_readdata_o == RAM_SIZE) else $error("size value wrong");
  chk_err_source: assert property ((bus_error_o & ~$past(unmapped_access_i)) == 5'h0)
    else $error("bus error without its access");
  chk_debug_quiet: assert property ($past(debug_mode_i) |-> bus_error_o[1:0] == 2'b00)
    else $error("cpu bus error in debug mode");
endmodule // bmcfg_monitor

bind bmcfg_top bmcfg_monitor #(.RAM_SIZE(RAM_SIZE)) u_mon (
  .ref_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
  .avs_waitrequest_o, .unmapped_access_i, .debug_mode_i, .bus_error_o, .cpu_ram_req_i,
  .cpu_ram_ready_o, .ram_wait_state_select_o);

// *** testbench/test_bus_matrix_config_ram_partition.sv ***
// Self-checking bench for the bus matrix configuration bank.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module test_bus_matrix_config_ram_partition import bmcfg_pkg::*;;
  localparam logic [31:0] RSZ = 32'h0000_8000;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o, q;
  logic avs_waitrequest_o, debug_mode_i = 1'b0, cpu_ram_req_i, cpu_ram_ready_o;
  logic [4:0] unmapped_access_i, bus_error_o, err_go = 5'h00;
  logic ram_go = 1'b0, ram_wait_state_select_o;
  logic [15:0] ram_addr = 16'h0, cpu_ram_addr_i, ram_kernel_program_base_o, ram_user_data_base_o;
  logic [2:0] arbitration_mode_select_o;
  bmcfg_part_type cpu_ram_part_o;
  int n_fail = 0;
  int samples_checked = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  bmcfg_top #(.RAM_SIZE(RSZ)) DUT (.ref_clk_i, .rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .unmapped_access_i, .debug_mode_i, .bus_error_o, .cpu_ram_req_i, .cpu_ram_addr_i,
    .cpu_ram_ready_o, .cpu_ram_part_o, .arbitration_mode_select_o, .ram_wait_state_select_o,
    .ram_kernel_program_base_o, .ram_user_data_base_o);
  bmcfg_initiators u_init (.ref_clk_i, .rst_i, .err_go_i(err_go), .ram_go_i(ram_go),
    .ram_addr_i(ram_addr), .unmapped_access_o(unmapped_access_i),
    .cpu_ram_req_o(cpu_ram_req_i), .cpu_ram_addr_o(cpu_ram_addr_i));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // An idle edge first keeps a strobe from being driven twice in one step.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 16);
    if (avs_waitrequest_o !== 1'b0) begin
      n_fail++;
      tally_and_finish();
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    `CHK("readdata", e, q)
  endtask
  task automatic err(input logic [4:0] p, input logic [4:0] e);
    err_go <= p;
    @(posedge ref_clk_i);
    err_go <= 5'h00;
    repeat (2) @(posedge ref_clk_i);
    `CHK("bus_error_o", e, bus_error_o)
  endtask
  // Latency counts edges from the one that drops the command.
  task automatic ram(input logic [15:0] a, input int lat, input bmcfg_part_type pt);
    int n;
    ram_addr <= a;
    ram_go <= 1'b1;
    @(posedge ref_clk_i);
    ram_go <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (cpu_ram_ready_o !== 1'b1 && n < 8);
    `CHK("ram latency", lat, n)
    `CHK("cpu_ram_part_o", pt, cpu_ram_part_o)
    if (n >= 8) tally_and_finish();
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rchk(8'h00, 32'h001f_0041);
    `CHK("arbitration", 3'h1, arbitration_mode_select_o)
    rchk(8'h10, 32'h0);
    rchk(8'h20, 32'h0);
    rchk(8'h50, 32'h0);
    ram(16'h0900, 3, BMCFG_PART_KERNEL_DATA);
    wr(8'h00, 32'hffff_ffe2);
    rchk(8'h00, 32'h001f_0042);
    wr(8'h40, 32'h0);
    rchk(8'h40, RSZ);
    for (int m = 0; m < 3; m++) begin
      wr(8'h00, 32'h001f_0000 | m);
      rchk(8'h00, 32'h001f_0000 | m);
      `CHK("arbitration", 3'(m), arbitration_mode_select_o)
    end
    `CHK("wait state", 1'b0, ram_wait_state_select_o)
    ram(16'h0100, 2, BMCFG_PART_KERNEL_DATA);
    wr(8'h10, 32'hffff_ffff);
    rchk(8'h10, 32'h0000_fc00);
    wr(8'h1c, 32'h0000_f8ff);
    rchk(8'h10, 32'h0000_0400);
    wr(8'h28, 32'h0000_0c00);
    wr(8'h24, 32'h0000_0400);
    rchk(8'h20, 32'h0000_0800);
    rchk(8'h18, 32'h0);
    `CHK("kernel base", 16'h0400, ram_kernel_program_base_o)
    `CHK("user base", 16'h0800, ram_user_data_base_o)
    ram(16'h03ff, 2, BMCFG_PART_KERNEL_DATA);
    ram(16'h0400, 2, BMCFG_PART_KERNEL_PROG);
    ram(16'h0800, 2, BMCFG_PART_USER_DATA);
    wr(8'h04, 32'h0000_0002);
    wr(8'h08, 32'h0000_0041);
    wr(8'h0c, 32'h0000_0003);
    rchk(8'h00, 32'h001f_0042);
    avs_byteenable_i <= 4'h1;
    wr(8'h00, 32'h0);
    avs_byteenable_i <= 4'hf;
    rchk(8'h00, 32'h001f_0000);
    for (int i = 0; i < 5; i++) err(5'h01 << i, 5'h01 << i);
    debug_mode_i <= 1'b1;
    err(5'h1f, 5'h1c);
    debug_mode_i <= 1'b0;
    wr(8'h04, 32'h001f_0000);
    err(5'h1f, 5'h00);
    wr(8'h08, 32'h0004_0000);
    err(5'h1f, 5'h04);
    // A reset in mid-run must clear the written bases and restore the config.
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rchk(8'h10, 32'h0);
    rchk(8'h20, 32'h0);
    rchk(8'h00, 32'h001f_0041);
    `CHK("kernel base", 16'h0000, ram_kernel_program_base_o)
    `CHK("cpu_ram_part_o", BMCFG_PART_KERNEL_DATA, cpu_ram_part_o)
    ram(16'h0c00, 3, BMCFG_PART_KERNEL_DATA);
    tally_and_finish();
  end
endmodule // test_bus_matrix_config_ram_partition
